// ==== supply_status_map.vh ====
// command codes, field positions, reset values and timing for the status and protection block
`ifndef SUPPLY_STATUS_MAP_VH
`define SUPPLY_STATUS_MAP_VH

// command codes on the parsed command port
`define CMD_EVT_W        4'h0
`define CMD_EVT_Q        4'h1
`define CMD_EVT_ENA_W    4'h2
`define CMD_EVT_ENA_Q    4'h3
`define CMD_UVP_EN_W     4'h4
`define CMD_UVP_EN_Q     4'h5
`define CMD_UVL_W        4'h6
`define CMD_UVL_Q        4'h7
`define CMD_UVP_DLY_W    4'h8
`define CMD_UVP_DLY_Q    4'h9
`define CMD_CP_EN_W      4'ha
`define CMD_CP_EN_Q      4'hb
`define CMD_CP_LVL_W     4'hc
`define CMD_CP_LVL_Q     4'hd
`define CMD_COND_Q       4'he
`define CMD_PROT_CLR     4'hf

// operational event register bit positions
`define BIT_CONSTANT_POWER_ACTIVE  15
`define BIT_POWER_LIMIT_ARMED      14
`define BIT_EXT_CURRENT_REF        13
`define BIT_EXT_VOLTAGE_REF        12
`define BIT_CURRENT_FOLDBACK_ARMED 11
`define BIT_OUTPUT_GATE_ON         10
`define BIT_INTERLOCK_ARMED        9
`define BIT_LOW_VOLTAGE_TRIP       8
`define BIT_FRONT_PANEL_CONTROL    7
`define BIT_SEQUENCE_STEP_RUNNING  6
`define BIT_FOLDBACK_ARMED         5
`define BIT_AUTO_RESTART_ARMED     4
`define BIT_TRIGGER_PENDING        3
`define BIT_FAULT_FREE             2
`define BIT_CURRENT_REGULATING     1
`define BIT_VOLTAGE_REGULATING     0

// reset values
`define RST_EVT_ENA      16'hffff
`define RST_UVP_EN       1'b0
`define RST_UVL          16'h0000
`define RST_UVP_DLY      8'h01
`define RST_CP_EN        1'b0
`define RST_CP_LVL       20'h00000

// limits and ratios
`define UVP_DLY_MIN      8'h01
`define UVP_DLY_MAX      8'hff
`define PCT_DEN          5'h14
`define PCT_NUM_BELOW    5'h13

// timing: one delay step is 0.1 s
`define CLK_PERIOD_NS    20
`define UVP_STEP_NS      100000000
`define UVP_STEP_CYC     (`UVP_STEP_NS / `CLK_PERIOD_NS)

`endif

// ==== run_state_event_capture.v ====
// rising-edge capture of condition bits into a clear-on-read event latch
`timescale 1ns/10ps
`default_nettype none

module run_state_event_capture #(
    parameter WIDTH = 16
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire [WIDTH-1:0] cond_i,
    input wire [WIDTH-1:0] ena_i,
    input wire clr_i,
    output wire [WIDTH-1:0] evt_o
);

    reg [WIDTH-1:0] cond_prev_r;
    reg [WIDTH-1:0] evt_r;
    reg [WIDTH-1:0] evt_nxt;
    wire [WIDTH-1:0] rise;

    // a level that only stays high produces no rise
    assign rise = cond_i & ~cond_prev_r;

    // a rise in the read cycle survives the clear and is seen on the next read
    always @* begin
        evt_nxt = clr_i ? {WIDTH{1'b0}} : evt_r;
        evt_nxt = evt_nxt | (rise & ena_i);
    end

    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cond_prev_r <= {WIDTH{1'b0}};
            evt_r <= {WIDTH{1'b0}};
        end else begin
            cond_prev_r <= cond_i;
            evt_r <= evt_nxt;
        end
    end

    assign evt_o = evt_r;

endmodule // run_state_event_capture

`default_nettype wire

// ==== supply_status_event_and_uvp.v ====
// operational event register, under-voltage protection and constant-power settings
`timescale 1ns/10ps
`default_nettype none
`include "supply_status_map.vh"

module supply_status_event_and_uvp #(
    parameter V_W = 16,
    parameter P_W = 20,
    parameter [V_W-1:0] RATED_V = 16'h1770,
    parameter [P_W-1:0] P_MAX_DW = 20'h02710,
    parameter STEP_CYC = `UVP_STEP_CYC
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire cmd_valid_i,
    input wire [3:0] cmd_code_i,
    input wire [31:0] cmd_data_i,
    input wire [15:0] cond_i,
    input wire [V_W-1:0] vset_i,
    input wire [V_W-1:0] vmeas_i,
    input wire out_on_i,
    output reg rsp_valid_o,
    output reg rsp_err_o,
    output reg [31:0] rsp_data_o,
    output reg out_disable_o,
    output reg low_voltage_trip_o,
    output reg uvp_active_o,
    output reg cp_en_o,
    output reg [P_W-1:0] cp_level_o,
    output reg [V_W-1:0] low_voltage_limit_o
);

    localparam CNT_W = 32;
    localparam [CNT_W-1:0] STEP_LAST = STEP_CYC - 1;

    // 95% of a voltage, rounded down
    function [V_W-1:0] below_pct;
        input [V_W-1:0] v;
        reg [V_W+4:0] prod;
        reg [V_W+4:0] quo;
        begin
            prod = v * `PCT_NUM_BELOW;
            quo = prod / `PCT_DEN;
            below_pct = quo[V_W-1:0];
        end
    endfunction

    // tenths of a watt to whole watts, nearest
    function [P_W-1:0] round_w;
        input [P_W-1:0] p;
        reg [P_W:0] s;
        reg [P_W:0] quo;
        begin
            s = {1'b0, p} + {{(P_W-3){1'b0}}, 4'h5};
            quo = s / 4'ha;
            round_w = quo[P_W-1:0];
        end
    endfunction

    // an accepted command of one code in this cycle
    function wr_hit;
        input ok;
        input [3:0] got;
        input [3:0] want;
        begin
            wr_hit = ok & (got == want);
        end
    endfunction

    reg [15:0] evt_ena_r;
    reg uvp_en_r;
    reg [V_W-1:0] uvl_r;
    reg [7:0] uvp_dly_r;
    reg cp_en_r;
    reg [P_W-1:0] cp_lvl_r;
    reg trip_r;
    reg [CNT_W-1:0] tick_cnt_r;
    reg [7:0] step_cnt_r;
    reg evt_clr;
    reg rsp_err_nxt;
    reg [31:0] rsp_data_nxt;
    reg [15:0] cond_vec;

    wire [15:0] evt_val;
    wire [V_W-1:0] uvl_ceil;
    wire [V_W+4:0] uvl_x20;
    wire uvl_usable;
    wire uvp_act;
    wire fault;
    wire step_tick;
    wire wr_ok;

    assign uvl_ceil = below_pct(vset_i);
    assign uvl_x20 = uvl_r * `PCT_DEN;
    assign uvl_usable = uvl_x20 >= RATED_V;
    assign uvp_act = uvp_en_r & uvl_usable;
    assign fault = uvp_act & out_on_i & (vmeas_i <= uvl_r) & ~trip_r;
    assign step_tick = fault & (tick_cnt_r == STEP_LAST);
    assign wr_ok = cmd_valid_i & ~rsp_err_nxt;

    // two bits reflect this block's own settings; the rest come from the supply
    always @* begin
        cond_vec = 16'h0000;
        cond_vec[`BIT_CONSTANT_POWER_ACTIVE] = cond_i[`BIT_CONSTANT_POWER_ACTIVE];
        cond_vec[`BIT_POWER_LIMIT_ARMED] = cp_en_r;
        cond_vec[`BIT_EXT_CURRENT_REF] = cond_i[`BIT_EXT_CURRENT_REF];
        cond_vec[`BIT_EXT_VOLTAGE_REF] = cond_i[`BIT_EXT_VOLTAGE_REF];
        cond_vec[`BIT_CURRENT_FOLDBACK_ARMED] = cond_i[`BIT_CURRENT_FOLDBACK_ARMED];
        cond_vec[`BIT_OUTPUT_GATE_ON] = cond_i[`BIT_OUTPUT_GATE_ON];
        cond_vec[`BIT_INTERLOCK_ARMED] = cond_i[`BIT_INTERLOCK_ARMED];
        cond_vec[`BIT_LOW_VOLTAGE_TRIP] = uvp_en_r;
        cond_vec[`BIT_FRONT_PANEL_CONTROL] = cond_i[`BIT_FRONT_PANEL_CONTROL];
        cond_vec[`BIT_SEQUENCE_STEP_RUNNING] = cond_i[`BIT_SEQUENCE_STEP_RUNNING];
        cond_vec[`BIT_FOLDBACK_ARMED] = cond_i[`BIT_FOLDBACK_ARMED];
        cond_vec[`BIT_AUTO_RESTART_ARMED] = cond_i[`BIT_AUTO_RESTART_ARMED];
        cond_vec[`BIT_TRIGGER_PENDING] = cond_i[`BIT_TRIGGER_PENDING];
        cond_vec[`BIT_FAULT_FREE] = cond_i[`BIT_FAULT_FREE];
        cond_vec[`BIT_CURRENT_REGULATING] = cond_i[`BIT_CURRENT_REGULATING];
        cond_vec[`BIT_VOLTAGE_REGULATING] = cond_i[`BIT_VOLTAGE_REGULATING];
    end

    // command decode: answer data and refusal
    always @* begin
        rsp_err_nxt = 1'b0;
        rsp_data_nxt = 32'h00000000;
        evt_clr = 1'b0;
        case (cmd_code_i)
            // the event latch has no write path; the refusal is the only effect
            `CMD_EVT_W: begin
                rsp_err_nxt = 1'b1;
            end
            `CMD_EVT_Q: begin
                rsp_data_nxt = {16'h0000, evt_val};
                evt_clr = cmd_valid_i;
            end
            `CMD_EVT_ENA_W: begin
                rsp_err_nxt = |cmd_data_i[31:16];
            end
            `CMD_EVT_ENA_Q: begin
                rsp_data_nxt = {16'h0000, evt_ena_r};
            end
            `CMD_UVP_EN_W: begin
                rsp_err_nxt = |cmd_data_i[31:1];
            end
            `CMD_UVP_EN_Q: begin
                rsp_data_nxt = {31'h00000000, uvp_en_r};
            end
            `CMD_UVL_W: begin
                rsp_err_nxt = |cmd_data_i[31:V_W];
            end
            `CMD_UVL_Q: begin
                rsp_data_nxt = {{(32-V_W){1'b0}}, uvl_r};
            end
            `CMD_UVP_DLY_W: begin
                rsp_err_nxt = (|cmd_data_i[31:8]) | (cmd_data_i[7:0] < `UVP_DLY_MIN);
            end
            `CMD_UVP_DLY_Q: begin
                rsp_data_nxt = {24'h000000, uvp_dly_r};
            end
            `CMD_CP_EN_W: begin
                rsp_err_nxt = |cmd_data_i[31:1];
            end
            `CMD_CP_EN_Q: begin
                rsp_data_nxt = {31'h00000000, cp_en_r};
            end
            `CMD_CP_LVL_W: begin
                rsp_err_nxt = (|cmd_data_i[31:P_W]) | (cmd_data_i[P_W-1:0] > P_MAX_DW);
            end
            `CMD_CP_LVL_Q: begin
                rsp_data_nxt = {{(32-P_W){1'b0}}, round_w(cp_lvl_r)};
            end
            `CMD_COND_Q: begin
                rsp_data_nxt = {16'h0000, cond_vec};
            end
            `CMD_PROT_CLR: begin
                rsp_err_nxt = 1'b0;
            end
            default: begin
                rsp_err_nxt = 1'b1;
            end
        endcase
    end

    run_state_event_capture #(
        .WIDTH(16)
    ) u_evt (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .cond_i(cond_vec),
        .ena_i(evt_ena_r),
        .clr_i(evt_clr),
        .evt_o(evt_val)
    );

    // settings registers
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            evt_ena_r <= `RST_EVT_ENA;
            uvp_en_r <= `RST_UVP_EN;
            uvl_r <= `RST_UVL;
            uvp_dly_r <= `RST_UVP_DLY;
            cp_en_r <= `RST_CP_EN;
            cp_lvl_r <= `RST_CP_LVL;
        end else begin
            if (wr_hit(wr_ok, cmd_code_i, `CMD_EVT_ENA_W)) begin
                evt_ena_r <= cmd_data_i[15:0];
            end
            if (wr_hit(wr_ok, cmd_code_i, `CMD_UVP_EN_W)) begin
                uvp_en_r <= cmd_data_i[0];
            end
            // the limit follows the programmed voltage down as well as being clamped on write
            if (wr_hit(wr_ok, cmd_code_i, `CMD_UVL_W)) begin
                if (cmd_data_i[V_W-1:0] > uvl_ceil) begin
                    uvl_r <= uvl_ceil;
                end else begin
                    uvl_r <= cmd_data_i[V_W-1:0];
                end
            end else if (uvl_r > uvl_ceil) begin
                uvl_r <= uvl_ceil;
            end
            if (wr_hit(wr_ok, cmd_code_i, `CMD_UVP_DLY_W)) begin
                uvp_dly_r <= cmd_data_i[7:0];
            end
            if (wr_hit(wr_ok, cmd_code_i, `CMD_CP_EN_W)) begin
                cp_en_r <= cmd_data_i[0];
            end
            if (wr_hit(wr_ok, cmd_code_i, `CMD_CP_LVL_W)) begin
                cp_lvl_r <= cmd_data_i[P_W-1:0];
            end
        end
    end

    // delay timer: restarts whenever the fault goes away, so a brief dip cannot trip
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_cnt_r <= {CNT_W{1'b0}};
            step_cnt_r <= 8'h00;
            trip_r <= 1'b0;
        end else begin
            if (!fault) begin
                tick_cnt_r <= {CNT_W{1'b0}};
                step_cnt_r <= 8'h00;
            end else if (step_tick) begin
                tick_cnt_r <= {CNT_W{1'b0}};
                step_cnt_r <= step_cnt_r + 8'h01;
            end else begin
                tick_cnt_r <= tick_cnt_r + 1'b1;
            end
            // clear takes priority only when no new trip lands in the same cycle
            if (step_tick && (step_cnt_r + 8'h01) == uvp_dly_r) begin
                trip_r <= 1'b1;
            end else if (wr_hit(wr_ok, cmd_code_i, `CMD_PROT_CLR)) begin
                trip_r <= 1'b0;
            end
        end
    end

    // answer port and registered outputs
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_err_o <= 1'b0;
            rsp_data_o <= 32'h00000000;
            out_disable_o <= 1'b0;
            low_voltage_trip_o <= 1'b0;
            uvp_active_o <= 1'b0;
            cp_en_o <= 1'b0;
            cp_level_o <= {P_W{1'b0}};
            low_voltage_limit_o <= {V_W{1'b0}};
        end else begin
            rsp_valid_o <= cmd_valid_i;
            if (cmd_valid_i) begin
                rsp_err_o <= rsp_err_nxt;
                rsp_data_o <= rsp_data_nxt;
            end
            out_disable_o <= trip_r;
            low_voltage_trip_o <= trip_r;
            uvp_active_o <= uvp_act;
            cp_en_o <= cp_en_r;
            cp_level_o <= cp_lvl_r;
            low_voltage_limit_o <= uvl_r;
        end
    end

endmodule // supply_status_event_and_uvp

`default_nettype wire

// ==== supply_status_event_and_uvp_assertions.sv ====
// concurrent checks on the status and protection block ports
`timescale 1ns/10ps
`default_nettype none
module supply_status_checker #(
    parameter V_W = 16,
    parameter [V_W-1:0] RATED_V = 16'h1770
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_code_i,
    input wire logic [V_W-1:0] vset_i,
    input wire logic out_on_i,
    input wire logic rsp_valid_o,
    input wire logic rsp_err_o,
    input wire logic [31:0] rsp_data_o,
    input wire logic low_voltage_trip_o,
    input wire logic uvp_active_o,
    input wire logic cp_en_o,
    input wire logic [V_W-1:0] low_voltage_limit_o
);
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (sys_rst_i);
AST_RSP_ONE: assert property (cmd_valid_i |=> rsp_valid_o) else $error("no answer");
AST_RSP_ONLY: assert property (!cmd_valid_i |=> !rsp_valid_o) else $error("stray answer");
AST_EVT_RO: assert property (cmd_valid_i && cmd_code_i == 4'h0 |=> rsp_err_o)
    else $error("event write taken");
AST_UVP_BOOL: assert property (cmd_valid_i && cmd_code_i == 4'h5 |=> rsp_data_o[31:1] == 31'h0)
    else $error("uvp enable not boolean");
AST_CP_READ: assert property (cmd_valid_i && cmd_code_i == 4'hb |=> rsp_data_o == {31'h0, cp_en_o})
    else $error("cp enable readback");
AST_UVL_BELOW: assert property ($stable(vset_i) ##1 $stable(vset_i)
    |-> 32'(low_voltage_limit_o) * 20 <= 32'(vset_i) * 19) else $error("limit above 95 percent of vset");
AST_UVP_FLOOR: assert property (uvp_active_o |-> 32'(low_voltage_limit_o) * 20 >= 32'(RATED_V))
    else $error("active below 5 percent");
AST_TRIP_CAUSE: assert property ($rose(low_voltage_trip_o)
    |-> $past(out_on_i, 2) && $past(out_on_i, 3) && $past(uvp_active_o, 2)) else $error("trip without held fault");
AST_TRIP_HOLD: assert property ($fell(low_voltage_trip_o)
    |-> $past(cmd_valid_i, 2) && $past(cmd_code_i, 2) == 4'hf) else $error("trip dropped without clear");
endmodule // supply_status_checker
bind supply_status_event_and_uvp supply_status_checker #(.V_W(V_W), .RATED_V(RATED_V)) i_chk (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .vset_i(vset_i), .out_on_i(out_on_i), .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o),
    .rsp_data_o(rsp_data_o), .low_voltage_trip_o(low_voltage_trip_o), .uvp_active_o(uvp_active_o),
    .cp_en_o(cp_en_o), .low_voltage_limit_o(low_voltage_limit_o));
`default_nettype wire

// ==== host_cmd_model.sv ====
// remote host: issues one parsed command at a time and collects the answer
`timescale 1ns/10ps
`default_nettype none
module host_cmd_model (
    input wire logic clk_sys_i,
    input wire logic rsp_valid_i,
    input wire logic rsp_err_i,
    input wire logic [31:0] rsp_data_i,
    output logic cmd_valid_o,
    output logic [3:0] cmd_code_o,
    output logic [31:0] cmd_data_o
);
initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 4'h0;
    cmd_data_o = 32'h0;
end
task automatic xfer(input logic [3:0] code, input logic [31:0] data, output logic seen, output logic err,
                    output logic [31:0] rdata);
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= code;
    cmd_data_o <= data;
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b0;
    // released data is scrambled so nothing leans on a stale word
    cmd_data_o <= ~data;
    #1;
    seen = rsp_valid_i;
    err = rsp_err_i;
    rdata = rsp_data_i;
endtask
endmodule // host_cmd_model
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the status and protection block
`timescale 1ns/10ps
`default_nettype none
`include "supply_status_map.vh"
module testbench;
logic clk_sys_i, sys_rst_i, out_on_i, cmd_valid, rsp_valid, rsp_err, out_dis, trip, uvp_act, cp_en;
logic [3:0] cmd_code;
logic [31:0] cmd_data, rsp_data;
logic [15:0] cond_i, vset_i, vmeas_i, low_voltage_limit;
logic [19:0] cp_lvl;
int num_errors = 0;
int cmp_count = 0;
supply_status_event_and_uvp #(.STEP_CYC(4)) i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_data_i(cmd_data), .cond_i(cond_i), .vset_i(vset_i),
    .vmeas_i(vmeas_i), .out_on_i(out_on_i), .rsp_valid_o(rsp_valid), .rsp_err_o(rsp_err), .rsp_data_o(rsp_data),
    .out_disable_o(out_dis), .low_voltage_trip_o(trip), .uvp_active_o(uvp_act), .cp_en_o(cp_en),
    .cp_level_o(cp_lvl), .low_voltage_limit_o(low_voltage_limit));
host_cmd_model i_host (.clk_sys_i(clk_sys_i), .rsp_valid_i(rsp_valid), .rsp_err_i(rsp_err),
    .rsp_data_i(rsp_data), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_data_o(cmd_data));
initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
end
task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
        $display("Error %s expected %h seen %h", nm, exp, got);
        num_errors++;
    end
endtask
task automatic cmd(input logic [3:0] code, input logic [31:0] data, input logic exp_err);
    logic s, e;
    logic [31:0] d;
    i_host.xfer(code, data, s, e, d);
    chk("answer strobe", 32'h1, {31'h0, s});
    chk("refusal", {31'h0, exp_err}, {31'h0, e});
endtask
task automatic q(input logic [3:0] code, input logic [31:0] exp);
    logic s, e;
    logic [31:0] d;
    i_host.xfer(code, 32'h0, s, e, d);
    chk("query strobe", 32'h1, {31'h0, s});
    chk("query data", exp, d);
endtask
task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    print_verdict;
end
initial begin
    sys_rst_i = 1'b1;
    cond_i = 16'h0;
    vset_i = 16'd6000;
    vmeas_i = 16'd6000;
    out_on_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    q(`CMD_EVT_ENA_Q, 32'hffff);
    q(`CMD_UVP_DLY_Q, 32'h1);
    cmd(`CMD_EVT_W, 32'hffff, 1'b1);
    q(`CMD_EVT_Q, 32'h0);
    for (int i = 0; i < 16; i++) begin
        if (i != 8 && i != 14) begin
            @(posedge clk_sys_i) cond_i <= 16'h1 << i;
            q(`CMD_EVT_Q, 32'h1 << i);
            q(`CMD_EVT_Q, 32'h0);
            @(posedge clk_sys_i) cond_i <= 16'h0;
        end
    end
    cmd(`CMD_EVT_ENA_W, 32'hfffe, 1'b0);
    @(posedge clk_sys_i) cond_i <= 16'h3;
    @(posedge clk_sys_i) cond_i <= 16'h0;
    repeat (3) @(posedge clk_sys_i);
    q(`CMD_EVT_Q, 32'h2);
    cmd(`CMD_EVT_ENA_W, 32'hffff, 1'b0);
    cmd(`CMD_CP_EN_W, 32'h2, 1'b1);
    cmd(`CMD_CP_EN_W, 32'h1, 1'b0);
    q(`CMD_CP_EN_Q, 32'h1);
    chk("power enable output", 32'h1, {31'h0, cp_en});
    cmd(`CMD_UVP_EN_W, 32'h1, 1'b0);
    q(`CMD_UVP_EN_Q, 32'h1);
    q(`CMD_EVT_Q, 32'h4100);
    q(`CMD_COND_Q, 32'h4100);
    cmd(`CMD_CP_LVL_W, 32'd10001, 1'b1);
    cmd(`CMD_CP_LVL_W, 32'd12345, 1'b1);
    q(`CMD_CP_LVL_Q, 32'h0);
    cmd(`CMD_CP_LVL_W, 32'd1235, 1'b0);
    q(`CMD_CP_LVL_Q, 32'd124);
    chk("power level output", 32'd1235, {12'h000, cp_lvl});
    cmd(`CMD_UVP_DLY_W, 32'h0, 1'b1);
    cmd(`CMD_UVP_DLY_W, 32'h2, 1'b0);
    q(`CMD_UVP_DLY_Q, 32'h2);
    @(posedge clk_sys_i) vset_i <= 16'd1000;
    cmd(`CMD_UVL_W, 32'd999, 1'b0);
    q(`CMD_UVL_Q, 32'd950);
    chk("limit output", 32'd950, {16'h0000, low_voltage_limit});
    @(posedge clk_sys_i) vset_i <= 16'd6000;
    cmd(`CMD_UVL_W, 32'd400, 1'b0);
    @(posedge clk_sys_i) out_on_i <= 1'b1;
    #1 chk("uvp active", 32'h1, {31'h0, uvp_act});
    @(posedge clk_sys_i) vmeas_i <= 16'd300;
    repeat (8) @(posedge clk_sys_i);
    #1 chk("trip early", 32'h0, {31'h0, trip});
    @(posedge clk_sys_i);
    #1 chk("trip", 32'h1, {31'h0, trip});
    chk("output disable", 32'h1, {31'h0, out_dis});
    @(posedge clk_sys_i) vmeas_i <= 16'd6000;
    cmd(`CMD_PROT_CLR, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys_i);
    #1 chk("trip cleared", 32'h0, {31'h0, trip});
    cmd(`CMD_UVL_W, 32'd200, 1'b0);
    @(posedge clk_sys_i) vmeas_i <= 16'd100;
    repeat (12) @(posedge clk_sys_i);
    #1 chk("trip below floor", 32'h0, {31'h0, trip});
    chk("uvp inactive", 32'h0, {31'h0, uvp_act});
    print_verdict;
end
endmodule // testbench
`default_nettype wire
